// ---- eemc_bench.sv ----
// Purpose: Self-checking bench for the emulated image controller
// Assumes: Reads answer two cycles after the strobe
// Notes:   Unarmed store locks until reset, so a reset follows it
`timescale 1ns/1ps
module eemc_bench;
   logic                mclk_in  = 1'b0;
   logic                rst_in   = 1'b1;
   eemc_pkg::eemc_req_t req      = '0;
   logic [7:0]          rdata;
   logic                busy;
   logic                rd_seen  = 1'b0;
   logic                rd_seen_d = 1'b0;
   logic [7:0]          exp_q[$];
   logic [7:0]          d[3];
   int                  failures = 0;
   int                  n_tests  = 0;

   // Clock
   always #4 mclk_in = ~mclk_in;

   eemc_top #(.DEPTH(32), .AW(5)) DUT (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(req),
      .rdata_out(rdata), .busy_out(busy));

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      n_tests++;
      if (seen !== want) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic end_of_test();
      if (failures == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   // One access per cycle; strobe stays up until the next call
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk_in);
      #1;
      req = {w, ~w, a, w ? v : 8'h00};
      if (!w)
         exp_q.push_back(v);
   endtask : acc

   task automatic idle();
      @(posedge mclk_in);
      #1;
      req = '0;
   endtask : idle

   // Bounded wait for a copy to finish
   task automatic settle();
      idle();
      repeat (3) @(posedge mclk_in);
      check({7'h00, busy}, 8'h01);
      for (int i = 0; i < 100 && busy !== 1'b0; i++)
         @(posedge mclk_in);
      check({7'h00, busy}, 8'h00);
   endtask : settle

   // Monitor: read data settles two cycles after the strobe
   always @(posedge mclk_in) begin
      if (rd_seen_d)
         check(rdata, exp_q.pop_front());
      rd_seen_d <= rd_seen;
      rd_seen   <= req.rd;
   end

   // Watchdog, far beyond the few hundred cycles needed
   initial begin
      #40000;
      failures++;
      end_of_test();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h2FF2));
      foreach (d[i]) d[i] = 8'($urandom);
      repeat (4) @(posedge mclk_in);
      #1;
      rst_in = 1'b0;
      // Reset values
      acc(0, 8'hC5, 8'h01);
      acc(0, 8'hC6, 8'h00);
      acc(0, 8'hB6, 8'h00);
      // Window traffic across the wrap
      acc(1, 8'hC5, 8'h81);
      acc(1, 8'hB6, 8'h1E);
      foreach (d[i]) acc(1, 8'hD1, d[i]);
      acc(0, 8'hB6, 8'h01);
      acc(1, 8'hB6, 8'h1E);
      foreach (d[i]) acc(0, 8'hD1, d[i]);
      // Disabled logic ignores the window
      acc(1, 8'hC5, 8'h01);
      acc(1, 8'hD1, 8'h5A);
      acc(0, 8'hD1, 8'h00);
      acc(0, 8'hB6, 8'h01);
      // Keyed store
      acc(1, 8'hC6, 8'h55);
      acc(0, 8'hC6, 8'h01);
      acc(1, 8'hC6, 8'hAA);
      acc(0, 8'hC6, 8'h02);
      acc(1, 8'hC5, 8'h82);
      acc(0, 8'hC5, 8'h82);
      acc(0, 8'hC6, 8'h00);
      acc(0, 8'hD1, 8'h00);
      settle();
      acc(0, 8'hC5, 8'h80);
      // Spoil one byte, then load restores the stored image
      acc(1, 8'hC5, 8'h81);
      acc(1, 8'hB6, 8'h00);
      acc(1, 8'hD1, ~d[2]);
      acc(1, 8'hC5, 8'h85);
      acc(0, 8'hC5, 8'h85);
      settle();
      acc(0, 8'hC5, 8'h81);
      acc(1, 8'hB6, 8'h1E);
      foreach (d[i]) acc(0, 8'hD1, d[i]);
      // Command without enable is dropped
      acc(1, 8'hC5, 8'h04);
      acc(0, 8'hC5, 8'h00);
      // Unarmed store locks until reset
      acc(1, 8'hC5, 8'h82);
      acc(0, 8'hC6, 8'h03);
      acc(0, 8'hC5, 8'h80);
      acc(1, 8'hC6, 8'h55);
      acc(1, 8'hC6, 8'hAA);
      acc(0, 8'hC6, 8'h03);
      // Reset clears the lock; a bad first key locks again
      idle();
      // Let the last read answer before reset clears the port
      repeat (2) @(posedge mclk_in);
      #1;
      rst_in = 1'b1;
      repeat (2) @(posedge mclk_in);
      #1;
      rst_in = 1'b0;
      acc(0, 8'hC6, 8'h00);
      acc(1, 8'hC6, 8'hAA);
      acc(0, 8'hC6, 8'h03);
      idle();
      repeat (3) @(posedge mclk_in);
      end_of_test();
   end
endmodule : eemc_bench

// ---- eemc_mem.sv ----
// Purpose: Small byte memory with registered read data
// Assumes: One write port and one read port on the same clock
// Notes:   Contents are not cleared by reset
`timescale 1ns/1ps
module eemc_mem #(
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   input  wire logic          mclk_in,
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [7:0]    wdata_in,
   input  wire logic [AW-1:0] raddr_in,
   output logic      [7:0]    rdata_out
);
   logic [7:0] mem_ff [DEPTH];

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Write port
   always_ff @(posedge mclk_in) begin
      if (we_in) begin
         mem_ff[waddr_in] <= wdata_in;
      end
   end

   // Registered read, one cycle latency
   always_ff @(posedge mclk_in) begin
      rdata_out <= mem_ff[raddr_in];
   end
endmodule : eemc_mem

// ---- eemc_pkg.sv ----
// Purpose: Shared constants and types for the emulated data image controller
// Assumes: 8-bit special function register port, 32-byte image
// Notes:   Offsets are the register addresses on the special function bus
package eemc_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] EEMC_ADDR_POINTER = 8'hB6;
   localparam logic [7:0] EEMC_ADDR_WINDOW  = 8'hD1;
   localparam logic [7:0] EEMC_ADDR_CONTROL = 8'hC5;
   localparam logic [7:0] EEMC_ADDR_KEY     = 8'hC6;

   // ----------------------------------------------------------------
   // Field positions and values
   // ----------------------------------------------------------------
   localparam int         EEMC_BIT_ENABLE   = 7;
   localparam int         EEMC_BIT_LOAD     = 2;
   localparam int         EEMC_BIT_STORE    = 1;
   localparam int         EEMC_BIT_AUTOSTEP = 0;
   localparam logic [7:0] EEMC_CONTROL_RST  = 8'h01;
   localparam logic [7:0] EEMC_KEY_RST      = 8'h00;
   localparam logic [7:0] EEMC_KEY_FIRST    = 8'h55;
   localparam logic [7:0] EEMC_KEY_SECOND   = 8'hAA;
   localparam logic [4:0] EEMC_POINTER_RST  = 5'h00;
   localparam logic [7:0] EEMC_WINDOW_RST   = 8'hFF;
   localparam logic [2:0] EEMC_RSVD_READ    = 3'h0;

   // Protection state codes as software reads them
   localparam logic [1:0] EEMC_PS_IDLE   = 2'h0;
   localparam logic [1:0] EEMC_PS_FIRST  = 2'h1;
   localparam logic [1:0] EEMC_PS_OPEN   = 2'h2;
   localparam logic [1:0] EEMC_PS_LOCKED = 2'h3;

   // Copy sequencer states
   typedef enum logic [1:0] {
      EEMC_IDLE,
      EEMC_LOAD,
      EEMC_STORE
   } eemc_copy_t;

   // Register bus request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } eemc_req_t;
endpackage : eemc_pkg

// ---- eemc_props.sv ----
// Purpose: Port checks for the emulated image controller
// Assumes: Read data answers two cycles after the read strobe
// Notes:   Bound to every eemc_top instance
`timescale 1ns/1ps
module eemc_props #(
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   input wire logic                mclk_in,
   input wire logic                rst_in,
   input wire eemc_pkg::eemc_req_t req_in,
   input wire logic [7:0]          rdata_out,
   input wire logic                busy_out
);
   // Copy spans two cycles per byte
   localparam int CPY_LEN = 2 * DEPTH;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   // Length of the current busy run, checked when busy drops
   logic [7:0] busy_run;
   always_ff @(posedge mclk_in) begin
      if (rst_in || !busy_out) begin
         busy_run <= 8'h00;
      end else begin
         busy_run <= busy_run + 8'h01;
      end
   end
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_ctl_rsvd;
      $past(req_in.rd && req_in.addr == 8'hC5, 2) |-> rdata_out[6:3] == 4'h0;
   endproperty
   a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("ctl rsvd");
   property p_key_rsvd;
      $past(req_in.rd && req_in.addr == 8'hC6, 2) |-> rdata_out[7:2] == 6'h00;
   endproperty
   a_key_rsvd: assert property (p_key_rsvd) else $error("key rsvd");
   property p_ptr_rsvd;
      $past(req_in.rd && req_in.addr == 8'hB6, 2) |-> rdata_out[7:5] == 3'h0;
   endproperty
   a_ptr_rsvd: assert property (p_ptr_rsvd) else $error("ptr rsvd");
   property p_copy_go;
      req_in.wr && req_in.addr == 8'hC5 && req_in.wdata[7] && req_in.wdata[2] && !busy_out
         |-> ##[1:2] busy_out;
   endproperty
   a_copy_go: assert property (p_copy_go) else $error("load idle");
   property p_no_copy;
      // Busy lags a start by a cycle, so no start may precede the write
      !(req_in.wr && req_in.addr == 8'hC5 && req_in.wdata[7] && req_in.wdata[2:1] != 2'h0) ##1
      (req_in.wr && req_in.addr == 8'hC5 && !req_in.wdata[7] && !busy_out)
         |=> !busy_out [*2];
   endproperty
   a_no_copy: assert property (p_no_copy) else $error("copy off");
   property p_zero_cmd;
      !(req_in.wr && req_in.addr == 8'hC5 && req_in.wdata[7] && req_in.wdata[2:1] != 2'h0) ##1
      (req_in.wr && req_in.addr == 8'hC5 && req_in.wdata[2:1] == 2'h0 && !busy_out)
         |=> !busy_out ##1 !busy_out;
   endproperty
   a_zero_cmd: assert property (p_zero_cmd) else $error("zero cmd");
   property p_copy_len;
      $fell(busy_out) |-> busy_run == 8'(CPY_LEN);
   endproperty
   a_copy_len: assert property (p_copy_len) else $error("copy len");
   // Busy lags the copy, so the next cycle proves the copy still ran
   property p_win_off;
      (req_in.rd && req_in.addr == 8'hD1 && busy_out) ##1 busy_out |=> rdata_out == 8'h00;
   endproperty
   a_win_off: assert property (p_win_off) else $error("win busy");
endmodule : eemc_props

bind eemc_top eemc_props #(.DEPTH(DEPTH), .AW(AW)) u_props (.mclk_in(mclk_in),
   .rst_in(rst_in), .req_in(req_in), .rdata_out(rdata_out), .busy_out(busy_out));

// ---- eemc_top.sv ----
// Purpose: Control, pointer and write protection of an emulated data image
// Assumes: CPU register port on mclk_in; non-volatile array is modelled
//          by a second eemc_mem; one byte copied per two cycles
// Notes:   Read data appears two cycles after the read strobe (port is a flop)
`timescale 1ns/1ps
// Functional notes
// RULE1 - Image access only while enable bit set
// RULE2 - Control bits 6:4 and 3 read zero
// RULE3 - Load bit copies all bytes into RAM
// RULE4 - Store bit programs all bytes when unlocked
// RULE5 - Software writes key 55 then AA
// RULE6 - Key bits 1:0 report protection state
// RULE7 - Pointer steps after window access, wraps
// RULE8 - One store relocks writes again
// RULE9 - Bad key or unarmed store locks forever; here reset clears the lock
// RULE10 - Window reads and writes byte at pointer
// RULE11 - Command bits self clear after copy
module eemc_top #(
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   input  wire logic                mclk_in,
   input  wire logic                rst_in,
   input  wire eemc_pkg::eemc_req_t req_in,
   output logic      [7:0]          rdata_out,
   output logic                     busy_out
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic                 enable_ff;
   logic                 autostep_ff;
   logic [AW-1:0]        pointer_ff;
   logic [1:0]           protect_state_ff;
   eemc_pkg::eemc_copy_t copy_ff;
   logic [AW-1:0]        cnt_ff;
   logic                 phase_ff;
   logic                 wr_ctl;
   logic                 wr_key;
   logic                 win_acc;
   logic                 ram_we;
   logic [AW-1:0]        ram_waddr;
   logic [7:0]           ram_wdata;
   logic [AW-1:0]        ram_raddr;
   logic [7:0]           ram_rdata;
   logic                 nv_we;
   logic [7:0]           nv_rdata;
   logic                 last_byte;

   assign wr_ctl    = req_in.wr && (req_in.addr == eemc_pkg::EEMC_ADDR_CONTROL);
   assign wr_key    = req_in.wr && (req_in.addr == eemc_pkg::EEMC_ADDR_KEY);
   // Window is dead while disabled or while a copy owns the RAM
   assign win_acc   = enable_ff && (copy_ff == eemc_pkg::EEMC_IDLE) &&
                      (req_in.addr == eemc_pkg::EEMC_ADDR_WINDOW) &&
                      (req_in.wr || req_in.rd); // [RULE1]
   assign last_byte = (cnt_ff == AW'(DEPTH - 1));

   // ----------------------------------------------------------------
   // Memories
   // ----------------------------------------------------------------
   // RAM write mux: CPU window or load copy
   always_comb begin
      ram_we    = 1'b0;
      ram_waddr = pointer_ff;
      ram_wdata = req_in.wdata;
      if (copy_ff == eemc_pkg::EEMC_LOAD) begin
         ram_we    = phase_ff; // [RULE3]
         ram_waddr = cnt_ff;
         ram_wdata = nv_rdata;
      end else if (win_acc && req_in.wr) begin
         ram_we = 1'b1; // [RULE10]
      end
   end

   assign ram_raddr = (copy_ff == eemc_pkg::EEMC_STORE) ? cnt_ff : pointer_ff;
   assign nv_we     = (copy_ff == eemc_pkg::EEMC_STORE) && phase_ff; // [RULE4]

   eemc_mem #(.DEPTH(DEPTH), .AW(AW)) u_ram (
      .mclk_in   (mclk_in),
      .we_in     (ram_we),
      .waddr_in  (ram_waddr),
      .wdata_in  (ram_wdata),
      .raddr_in  (ram_raddr),
      .rdata_out (ram_rdata)
   );

   eemc_mem #(.DEPTH(DEPTH), .AW(AW)) u_nv (
      .mclk_in   (mclk_in),
      .we_in     (nv_we),
      .waddr_in  (cnt_ff),
      .wdata_in  (ram_rdata),
      .raddr_in  (cnt_ff),
      .rdata_out (nv_rdata)
   );

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Enable and autostep; commands live in the copy sequencer
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         enable_ff   <= eemc_pkg::EEMC_CONTROL_RST[eemc_pkg::EEMC_BIT_ENABLE];
         autostep_ff <= eemc_pkg::EEMC_CONTROL_RST[eemc_pkg::EEMC_BIT_AUTOSTEP];
      end else if (wr_ctl) begin
         enable_ff   <= req_in.wdata[eemc_pkg::EEMC_BIT_ENABLE];
         autostep_ff <= req_in.wdata[eemc_pkg::EEMC_BIT_AUTOSTEP];
      end
   end

   // ----------------------------------------------------------------
   // Byte pointer
   // ----------------------------------------------------------------
   // Natural wrap of the 5-bit counter brings top address back to 0
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         pointer_ff <= eemc_pkg::EEMC_POINTER_RST;
      end else if (req_in.wr && req_in.addr == eemc_pkg::EEMC_ADDR_POINTER) begin
         pointer_ff <= req_in.wdata[AW-1:0];
      end else if (win_acc && autostep_ff) begin
         pointer_ff <= pointer_ff + AW'(1); // [RULE7]
      end
   end

   // ----------------------------------------------------------------
   // Copy sequencer
   // ----------------------------------------------------------------
   // Two cycles per byte: address, then move registered data
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         copy_ff  <= eemc_pkg::EEMC_IDLE;
         cnt_ff   <= '0;
         phase_ff <= 1'b0;
      end else begin
         unique case (copy_ff)
            eemc_pkg::EEMC_IDLE: begin
               cnt_ff   <= '0;
               phase_ff <= 1'b0;
               if (wr_ctl && req_in.wdata[eemc_pkg::EEMC_BIT_ENABLE]) begin
                  if (req_in.wdata[eemc_pkg::EEMC_BIT_LOAD]) begin
                     copy_ff <= eemc_pkg::EEMC_LOAD; // [RULE3] [RULE1]
                  end else if (req_in.wdata[eemc_pkg::EEMC_BIT_STORE] &&
                               protect_state_ff == eemc_pkg::EEMC_PS_OPEN) begin
                     copy_ff <= eemc_pkg::EEMC_STORE; // [RULE4]
                  end
               end
            end
            eemc_pkg::EEMC_LOAD,
            eemc_pkg::EEMC_STORE: begin
               phase_ff <= ~phase_ff;
               if (phase_ff) begin
                  cnt_ff <= cnt_ff + AW'(1);
                  if (last_byte) begin
                     copy_ff <= eemc_pkg::EEMC_IDLE; // [RULE11]
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Write protection
   // ----------------------------------------------------------------
   // Locked is terminal; only reset leaves it
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         protect_state_ff <= eemc_pkg::EEMC_KEY_RST[1:0];
      end else if (protect_state_ff != eemc_pkg::EEMC_PS_LOCKED) begin
         if (wr_ctl && req_in.wdata[eemc_pkg::EEMC_BIT_STORE] &&
             req_in.wdata[eemc_pkg::EEMC_BIT_ENABLE] &&
             !req_in.wdata[eemc_pkg::EEMC_BIT_LOAD] &&
             copy_ff == eemc_pkg::EEMC_IDLE) begin
            if (protect_state_ff == eemc_pkg::EEMC_PS_OPEN) begin
               protect_state_ff <= eemc_pkg::EEMC_PS_IDLE; // [RULE8]
            end else begin
               protect_state_ff <= eemc_pkg::EEMC_PS_LOCKED; // [RULE9]
            end
         end else if (wr_key) begin
            unique case (protect_state_ff)
               eemc_pkg::EEMC_PS_IDLE:
                  protect_state_ff <= (req_in.wdata == eemc_pkg::EEMC_KEY_FIRST) ?
                     eemc_pkg::EEMC_PS_FIRST : eemc_pkg::EEMC_PS_LOCKED; // [RULE5] [RULE9]
               eemc_pkg::EEMC_PS_FIRST:
                  protect_state_ff <= (req_in.wdata == eemc_pkg::EEMC_KEY_SECOND) ?
                     eemc_pkg::EEMC_PS_OPEN : eemc_pkg::EEMC_PS_LOCKED; // [RULE5] [RULE9]
               default:
                  protect_state_ff <= eemc_pkg::EEMC_PS_LOCKED; // [RULE9]
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data and busy
   // ----------------------------------------------------------------
   // Source select stage; window data comes from the RAM's own register
   logic       rd_win_ff;
   logic [7:0] rd_reg_ff;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rd_win_ff <= 1'b0;
         rd_reg_ff <= 8'h00;
      end else begin
         rd_win_ff <= req_in.rd && win_acc; // [RULE10]
         unique case (req_in.addr)
            eemc_pkg::EEMC_ADDR_CONTROL:
               rd_reg_ff <= {enable_ff, eemc_pkg::EEMC_RSVD_READ, 1'b0,
                             copy_ff == eemc_pkg::EEMC_LOAD,
                             copy_ff == eemc_pkg::EEMC_STORE,
                             autostep_ff}; // [RULE2] [RULE11]
            eemc_pkg::EEMC_ADDR_KEY:
               rd_reg_ff <= {6'h00, protect_state_ff}; // [RULE6]
            eemc_pkg::EEMC_ADDR_POINTER:
               rd_reg_ff <= {3'h0, pointer_ff};
            default:
               rd_reg_ff <= 8'h00;
         endcase
      end
   end

   // Port driven from a flop; costs one cycle of read latency
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= rd_win_ff ? ram_rdata : rd_reg_ff; // [RULE10]
      end
   end

   // Busy flag mirrors the sequencer
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         busy_out <= 1'b0;
      end else begin
         busy_out <= (copy_ff != eemc_pkg::EEMC_IDLE);
      end
   end
endmodule : eemc_top
